// >>> design/lcd_clk_defs.svh
// named offsets, field positions, reset values and divider exponents for the lcd clock select block
// assumes inclusion by bare name from the design files
`ifndef LCD_CLK_DEFS_SVH
`define LCD_CLK_DEFS_SVH

// byte addresses on the register bus
`define LCD_CTRL_ADDR 8'h28
`define LCD_STAT_ADDR 8'h2c

// control register layout and reset value
`define LCD_CTRL_RESET 8'h00
`define CTRL_DISPLAY_BIT 7
`define CTRL_BOOSTER_BIT 6
`define CTRL_BOOST_HI 5
`define CTRL_BOOST_LO 4
`define CTRL_DUTY_HI 3
`define CTRL_DUTY_LO 2
`define CTRL_FRAME_HI 1
`define CTRL_FRAME_LO 0

// status register layout
`define STAT_PHASE_LO 0
`define STAT_PHASE_HI 1
`define STAT_LOW_SRC_BIT 2
`define STAT_BOOSTER_BIT 3

// chain lengths
`define HIGH_CHAIN_LEN 17
`define LOW_CHAIN_LEN 9

// frame base exponents, high clock then low clock
`define FRAME_EXP_HIGH_00 17
`define FRAME_EXP_HIGH_01 16
`define FRAME_EXP_HIGH_10 15
`define FRAME_EXP_HIGH_11 13
`define FRAME_EXP_LOW_00 9
`define FRAME_EXP_LOW_01 8

// the phase tick runs four times the base rate
`define PHASE_PER_BASE_EXP 2

// booster reference exponents
`define BOOST_EXP_HIGH_00 13
`define BOOST_EXP_HIGH_01 11
`define BOOST_EXP_HIGH_10 10
`define BOOST_EXP_HIGH_11 9
`define BOOST_EXP_LOW_00 5
`define BOOST_EXP_LOW_01 3
`define BOOST_EXP_LOW_10 2

// last phase index of a frame for each drive method
`define LAST_PHASE_QUARTER 2'h3
`define LAST_PHASE_THIRD 2'h2
`define LAST_PHASE_HALF 2'h1
`define LAST_PHASE_STATIC 2'h3

`endif

// >>> design/lcd_clk_pkg.sv
// types shared by the lcd clock select block
// assumes nothing beyond a systemverilog compiler
package lcd_clk_pkg;

   // drive method field encodings
   typedef enum logic [1:0] {
      duty_quarter = 2'h0,
      duty_third = 2'h1,
      duty_half = 2'h2,
      duty_static = 2'h3
   } drive_method_t;

   // state of one prescaler chain
   typedef struct packed {
      logic [16:0] count;
      logic [16:0] ticks;
   } prescale_state_t;

   // state of the top module
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic ack;
      logic [1:0] phase;
      logic phase_tick;
      logic frame_tick;
      logic boost_tick;
   } top_state_t;

endpackage : lcd_clk_pkg

// >>> design/lcd_prescaler.sv
// free-running binary divider chain advanced by a source enable pulse
// assumes src_tick is a one-cycle pulse synchronous to clock
`timescale 1ns/100ps
module lcd_prescaler
   import lcd_clk_pkg::*;
#(
   parameter int LEN = 17
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic src_tick,
   output logic [LEN-1:0] stage_tick
);

   prescale_state_t state_reg;
   prescale_state_t state_next;

   // stage k pulses once per 2^(k+1) source pulses; no halt input, so it never stops
   always_comb begin
      logic carry;
      carry = src_tick;
      state_next = state_reg;
      state_next.ticks = '0;
      if (src_tick) begin
         state_next.count = state_reg.count + 17'h00001;
      end
      // rippled and of the low count bits keeps every bit select constant
      for (int k = 0; k < LEN; k++) begin
         carry = carry & state_reg.count[k];
         state_next.ticks[k] = carry;
      end
   end

   // registered so the selected pulse is a clean flop output
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign stage_tick = state_reg.ticks[LEN-1:0];

endmodule : lcd_prescaler

// >>> design/lcd_frame_boost_clock_select.sv
// lcd frame and booster clock selection with its control register on a classic wishbone slave
// assumes the two source clocks arrive as one-cycle enable pulses synchronous to clock
// assumes software keeps the duty and frame-field limits; nothing here blocks a misuse
// Overview of operation
// RULE1: drive method field picks quarter, third, half duty or static drive.
// RULE2: high clock frame base is fc over 2^17, 2^16, 2^15, 2^13.
// RULE3: frame rate equals base for quarter and static, 4/3 third, 4/2 half.
// RULE4: low clock frame base is fs over 2^9 for 00, 2^8 for 01.
// RULE5: booster bit set uses internal booster, clear uses external resistor divider.
// RULE6: boost field picks fc over 2^13/11/10/9 or fs over 2^5/3/2.
// RULE7: software keeps third bias, no half or static duty with booster on.
// RULE8: software avoids frame field 10 or 11 in slow low clock modes.
// RULE9: control register resets to zero; bits display, booster, boost, duty, frame.
// RULE10: dividers free-run from the selected source, unaffected by processor halts.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "lcd_clk_defs.svh"
module lcd_frame_boost_clock_select
   import lcd_clk_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic high_freq_clock,
   input wire logic low_freq_clock,
   input wire logic divider_stage_src_sel,
   input wire logic system_clock_src_sel,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic display_on,
   output logic booster_on,
   output logic [1:0] boost_freq_sel,
   output logic [1:0] drive_method,
   output logic [1:0] frame_base_sel,
   output logic low_src_active,
   output logic common_phase_tick,
   output logic [1:0] common_index,
   output logic frame_tick,
   output logic boost_clock_tick
);

   top_state_t state_reg;
   top_state_t state_next;
   logic [`HIGH_CHAIN_LEN-1:0] high_ticks;
   logic [`LOW_CHAIN_LEN-1:0] low_ticks;
   logic use_low;
   logic quarter_base;
   logic boost_src;
   logic [1:0] last_phase;
   logic bus_req;

   // pulse of the high chain that divides by 2^exp
   function automatic logic high_pick(input logic [`HIGH_CHAIN_LEN-1:0] t, input int exp);
      high_pick = t[exp-1];
   endfunction : high_pick

   // pulse of the low chain that divides by 2^exp
   function automatic logic low_pick(input logic [`LOW_CHAIN_LEN-1:0] t, input int exp);
      low_pick = t[exp-1];
   endfunction : low_pick

   // address compare shared by both register decodes
   function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] target);
      addr_hit = (adr == target);
   endfunction : addr_hit

   // status word: phase index, source in use, booster state; upper bits read zero
   function automatic logic [7:0] status_word(input logic [1:0] phase, input logic low, input logic boost);
      status_word = 8'h00;
      status_word[`STAT_PHASE_HI:`STAT_PHASE_LO] = phase;
      status_word[`STAT_LOW_SRC_BIT] = low;
      status_word[`STAT_BOOSTER_BIT] = boost;
   endfunction : status_word

   // both chains run all the time so switching sources needs no restart
   lcd_prescaler #(.LEN(`HIGH_CHAIN_LEN)) u_high_chain ( // [RULE10]
      .clock(clock),
      .srst(srst),
      .src_tick(high_freq_clock),
      .stage_tick(high_ticks)
   );

   // low chain spans the 2^9 frame base, though its deepest tap (2^7) needs only 7 stages
   lcd_prescaler #(.LEN(`LOW_CHAIN_LEN)) u_low_chain ( // [RULE10]
      .clock(clock),
      .srst(srst),
      .src_tick(low_freq_clock),
      .stage_tick(low_ticks)
   );

   // either select moves the taps onto the low clock, except frame field 1x and boost code 11
   assign use_low = divider_stage_src_sel | system_clock_src_sel;

   // quarter-base pulse; frame field 1x always falls back to the high chain
   always_comb begin
      quarter_base = 1'b0;
      case (state_reg.ctrl[`CTRL_FRAME_HI:`CTRL_FRAME_LO])
         2'h0: begin
            if (use_low) begin
               quarter_base = low_pick(low_ticks, `FRAME_EXP_LOW_00 - `PHASE_PER_BASE_EXP); // [RULE4]
            end else begin
               quarter_base = high_pick(high_ticks, `FRAME_EXP_HIGH_00 - `PHASE_PER_BASE_EXP); // [RULE2]
            end
         end
         2'h1: begin
            if (use_low) begin
               quarter_base = low_pick(low_ticks, `FRAME_EXP_LOW_01 - `PHASE_PER_BASE_EXP); // [RULE4]
            end else begin
               quarter_base = high_pick(high_ticks, `FRAME_EXP_HIGH_01 - `PHASE_PER_BASE_EXP); // [RULE2]
            end
         end
         2'h2: quarter_base = high_pick(high_ticks, `FRAME_EXP_HIGH_10 - `PHASE_PER_BASE_EXP); // [RULE2]
         2'h3: quarter_base = high_pick(high_ticks, `FRAME_EXP_HIGH_11 - `PHASE_PER_BASE_EXP); // [RULE2]
         default: quarter_base = 1'b0;
      endcase
   end

   // booster reference; code 11 has no low-clock tap, so it stays on the high chain
   always_comb begin
      boost_src = 1'b0;
      case (state_reg.ctrl[`CTRL_BOOST_HI:`CTRL_BOOST_LO])
         2'h0: begin
            if (use_low) begin
               boost_src = low_pick(low_ticks, `BOOST_EXP_LOW_00); // [RULE6]
            end else begin
               boost_src = high_pick(high_ticks, `BOOST_EXP_HIGH_00); // [RULE6]
            end
         end
         2'h1: begin
            if (use_low) begin
               boost_src = low_pick(low_ticks, `BOOST_EXP_LOW_01); // [RULE6]
            end else begin
               boost_src = high_pick(high_ticks, `BOOST_EXP_HIGH_01); // [RULE6]
            end
         end
         2'h2: begin
            if (use_low) begin
               boost_src = low_pick(low_ticks, `BOOST_EXP_LOW_10); // [RULE6]
            end else begin
               boost_src = high_pick(high_ticks, `BOOST_EXP_HIGH_10); // [RULE6]
            end
         end
         2'h3: boost_src = high_pick(high_ticks, `BOOST_EXP_HIGH_11); // [RULE6]
         default: boost_src = 1'b0;
      endcase
   end

   // phases per frame set the frame rate relative to the base
   always_comb begin
      last_phase = `LAST_PHASE_QUARTER;
      case (drive_method_t'(state_reg.ctrl[`CTRL_DUTY_HI:`CTRL_DUTY_LO])) // [RULE1]
         duty_quarter: last_phase = `LAST_PHASE_QUARTER; // [RULE3]
         duty_third: last_phase = `LAST_PHASE_THIRD; // [RULE3]
         duty_half: last_phase = `LAST_PHASE_HALF; // [RULE3]
         duty_static: last_phase = `LAST_PHASE_STATIC; // [RULE3]
         default: last_phase = `LAST_PHASE_QUARTER;
      endcase
   end

   // a strobe still held in the ack cycle is not taken again, so each access is answered once
   assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;

   // next state: bus slave, phase counter and registered pulses
   always_comb begin
      state_next = state_reg;
      state_next.ack = bus_req; // one-cycle ack, dropped the cycle after
      state_next.phase_tick = quarter_base;
      state_next.frame_tick = 1'b0;
      state_next.boost_tick = boost_src & state_reg.ctrl[`CTRL_BOOSTER_BIT]; // [RULE5]
      // phase counter advances on each quarter-base pulse
      if (quarter_base) begin
         // a duty change mid-frame may leave phase above the new last; wrap it on the next quarter-base pulse
         if (state_reg.phase >= last_phase) begin
            state_next.phase = 2'h0;
            state_next.frame_tick = 1'b1; // [RULE3]
         end else begin
            state_next.phase = state_reg.phase + 2'h1;
         end
      end
      // register access; a read returns the value held before a write in the same cycle
      if (bus_req) begin
         state_next.rdata = 8'h00; // unmapped addresses read zero
         if (addr_hit(wb_adr_i, `LCD_CTRL_ADDR)) begin
            state_next.rdata = state_reg.ctrl;
            if (wb_we_i && wb_sel_i[0]) begin
               state_next.ctrl = wb_dat_i[7:0]; // [RULE9]
            end
         end else if (addr_hit(wb_adr_i, `LCD_STAT_ADDR)) begin
            state_next.rdata = status_word(state_reg.phase, use_low, state_reg.ctrl[`CTRL_BOOSTER_BIT]);
         end
      end
   end

   // single register stage for this module's state; the two chains keep their own flops
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= '0;
         state_reg.ctrl <= `LCD_CTRL_RESET; // [RULE9]
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign wb_dat_o = {24'h000000, state_reg.rdata};
   assign wb_ack_o = state_reg.ack;

   // control fields and the source in use as levels for the panel side
   assign display_on = state_reg.ctrl[`CTRL_DISPLAY_BIT];
   assign booster_on = state_reg.ctrl[`CTRL_BOOSTER_BIT]; // [RULE5]
   assign boost_freq_sel = state_reg.ctrl[`CTRL_BOOST_HI:`CTRL_BOOST_LO];
   assign drive_method = state_reg.ctrl[`CTRL_DUTY_HI:`CTRL_DUTY_LO]; // [RULE1]
   assign frame_base_sel = state_reg.ctrl[`CTRL_FRAME_HI:`CTRL_FRAME_LO];
   assign low_src_active = use_low;

   // timing pulses and phase index for the common drivers
   assign common_phase_tick = state_reg.phase_tick;
   assign common_index = state_reg.phase;
   assign frame_tick = state_reg.frame_tick;
   assign boost_clock_tick = state_reg.boost_tick;

endmodule : lcd_frame_boost_clock_select

// >>> dv/lcd_clk_checker.sv
// port assertions for the lcd clock select block
// assumes one clock domain with synchronous active-high srst
`timescale 1ns/100ps
`include "lcd_clk_defs.svh"
module lcd_clk_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic divider_stage_src_sel,
   input wire logic system_clock_src_sel,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic display_on,
   input wire logic booster_on,
   input wire logic [1:0] boost_freq_sel,
   input wire logic [1:0] drive_method,
   input wire logic [1:0] frame_base_sel,
   input wire logic low_src_active,
   input wire logic common_phase_tick,
   input wire logic [1:0] common_index,
   input wire logic frame_tick,
   input wire logic boost_clock_tick
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // a bus request still waiting for its answer
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ctrl_wr; s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `LCD_CTRL_ADDR); endsequence
   property p_ack_next; s_req |=> wb_ack_o; endproperty
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ctrl_wr;
      s_ctrl_wr |=> {display_on, booster_on, boost_freq_sel, drive_method, frame_base_sel} == $past(wb_dat_i[7:0]);
   endproperty
   property p_low_src; low_src_active == (divider_stage_src_sel || system_clock_src_sel); endproperty
   property p_frame_wrap; frame_tick |-> common_phase_tick && common_index == 2'h0; endproperty
   property p_phase_step;
      common_phase_tick && !frame_tick |-> common_index == 2'($past(common_index) + 2'h1);
   endproperty
   // a duty change may leave the index high until the next tick
   property p_half_range; common_phase_tick && drive_method == 2'h2 && $stable(drive_method) |-> common_index <= 2'h1;
   endproperty
   property p_boost_off; !booster_on ##1 !booster_on |-> !boost_clock_tick; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control fields differ from write");
   a_low_src: assert property (p_low_src) else $error("source select wrong");
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame tick off phase zero");
   a_phase_step: assert property (p_phase_step) else $error("phase index skipped");
   a_half_range: assert property (p_half_range) else $error("half duty index too high");
   a_boost_off: assert property (p_boost_off) else $error("boost tick with booster off");
endmodule : lcd_clk_checker
bind lcd_frame_boost_clock_select lcd_clk_checker u_chk (.clock(clock), .srst(srst),
   .divider_stage_src_sel(divider_stage_src_sel), .system_clock_src_sel(system_clock_src_sel),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .display_on(display_on), .booster_on(booster_on),
   .boost_freq_sel(boost_freq_sel), .drive_method(drive_method), .frame_base_sel(frame_base_sel),
   .low_src_active(low_src_active), .common_phase_tick(common_phase_tick), .common_index(common_index),
   .frame_tick(frame_tick), .boost_clock_tick(boost_clock_tick));

// >>> dv/lcd_panel_model.sv
// panel model counting common phases in each frame
// assumes tick inputs are one-cycle pulses on clock
`timescale 1ns/100ps
module lcd_panel_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic common_phase_tick,
   input wire logic frame_tick,
   output logic [2:0] phases_per_frame
);
   logic [2:0] count_reg;
   // frame tick closes a frame; it is itself the frame's last phase
   always_ff @(posedge clock) begin
      if (srst) begin
         count_reg <= 3'h0;
         phases_per_frame <= 3'h0;
      end else if (frame_tick) begin
         phases_per_frame <= count_reg + 3'h1;
         count_reg <= 3'h0;
      end else if (common_phase_tick) begin
         count_reg <= count_reg + 3'h1;
      end
   end
endmodule : lcd_panel_model

// >>> dv/lcd_frame_boost_clock_select_tb.sv
// testbench: register access, tick spacing per field, panel frame lengths
// assumes the design and the panel model compiled before it
`timescale 1ns/100ps
`include "lcd_clk_defs.svh"
module lcd_frame_boost_clock_select_tb;
   logic clock, wb_ack_o, display_on, booster_on, low_src_active, common_phase_tick, frame_tick, boost_clock_tick;
   logic srst = 1'b1, high_freq_clock = 1'b0, low_freq_clock = 1'b0;
   logic divider_stage_src_sel = 1'b0, system_clock_src_sel = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 4'h0;
   logic [1:0] boost_freq_sel, drive_method, frame_base_sel, common_index, src_cnt = 2'h0;
   logic [2:0] phases_per_frame;
   int err_total = 0, n_tests = 0, i;
   int fb_exp[4] = '{4096, 16384, 512, 256};
   int bs_exp[4] = '{128, 32, 16, 1024};
   int ph_cnt[4] = '{4, 3, 2, 4};
   logic [7:0] fb_val[4] = '{8'h03, 8'h02, 8'h00, 8'h01};
   lcd_frame_boost_clock_select DUT (.clock(clock), .srst(srst), .high_freq_clock(high_freq_clock),
      .low_freq_clock(low_freq_clock), .divider_stage_src_sel(divider_stage_src_sel),
      .system_clock_src_sel(system_clock_src_sel), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .display_on(display_on), .booster_on(booster_on), .boost_freq_sel(boost_freq_sel),
      .drive_method(drive_method), .frame_base_sel(frame_base_sel), .low_src_active(low_src_active),
      .common_phase_tick(common_phase_tick), .common_index(common_index), .frame_tick(frame_tick),
      .boost_clock_tick(boost_clock_tick));
   lcd_panel_model panel (.clock(clock), .srst(srst), .common_phase_tick(common_phase_tick),
      .frame_tick(frame_tick), .phases_per_frame(phases_per_frame));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // free-running sources: high every 2 cycles, low every 4
   always @(posedge clock) begin
      src_cnt <= src_cnt + 2'h1;
      high_freq_clock <= src_cnt[0];
      low_freq_clock <= (src_cnt == 2'h0);
   end
   task end_of_test;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle; read data taken at the ack edge
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      int k;
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= {24'h0, d}; wb_sel_i <= 4'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (wb_ack_o === 1'b1) break;
      end
      if (k == 20) begin err_total++; end_of_test; end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask : bus
   function logic tk(input int w);
      return (w == 0) ? common_phase_tick : (w == 1) ? frame_tick : boost_clock_tick;
   endfunction : tk
   // third gap is measured; the first ticks may straddle a change
   task gap(input int w, input int e);
      int c;
      int k;
      for (k = 0; k < 3; k++) begin
         c = 0;
         do begin @(posedge clock); c++; end while (tk(w) !== 1'b1 && c < 40000);
      end
      if (c >= 40000) begin err_total++; end_of_test; end
      chk(32'(c), 32'(e));
   endtask : gap
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      bus(0, `LCD_CTRL_ADDR, 8'h00, q); chk(q, 32'h0);
      bus(0, `LCD_STAT_ADDR, 8'h00, q); chk(q, 32'h0);
      bus(0, 8'h30, 8'h00, q); chk(q, 32'h0); // unmapped reads zero
      bus(1, `LCD_CTRL_ADDR, 8'hc1, q);
      bus(1, `LCD_STAT_ADDR, 8'h3c, q);
      bus(0, `LCD_CTRL_ADDR, 8'h00, q); chk(q, 32'hc1);
      chk({24'h0, display_on, booster_on, boost_freq_sel, drive_method, frame_base_sel}, 32'hc1);
      divider_stage_src_sel <= 1'b1;
      bus(0, `LCD_STAT_ADDR, 8'h00, q); chk(q & 32'hc, 32'hc);
      for (i = 0; i < 4; i++) begin
         divider_stage_src_sel <= i[1];
         bus(1, `LCD_CTRL_ADDR, fb_val[i], q);
         gap(0, fb_exp[i]);
      end
      for (i = 0; i < 4; i++) begin
         bus(1, `LCD_CTRL_ADDR, {4'h0, 2'(i), 2'h1}, q);
         gap(1, ph_cnt[i] * 256);
         chk({29'h0, phases_per_frame}, 32'(ph_cnt[i]));
      end
      divider_stage_src_sel <= 1'b0;
      system_clock_src_sel <= 1'b1;
      for (i = 0; i < 4; i++) begin
         bus(1, `LCD_CTRL_ADDR, {2'h1, 2'(i), 4'h0}, q);
         gap(2, bs_exp[i]);
      end
      // high source with a booster code that has a low-clock tap as well
      system_clock_src_sel <= 1'b0;
      bus(1, `LCD_CTRL_ADDR, {2'h1, 2'h2, 4'h0}, q);
      gap(2, 2048);
      end_of_test;
   end
endmodule : lcd_frame_boost_clock_select_tb
